// file: rtl/adc_ctrl_top.sv
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_top (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic external_trigger_pin_i,
   input wire logic [3:0] timer_req_i,
   input wire logic [9:0] conv_code_i,
   output logic sample_hold_o,
   output logic convert_busy_o,
   output logic [1:0] channel_o,
   output logic conversion_end_irq_o
);

   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONV} seq_state_t;

   seq_state_t st_ff, nxt_st;
   logic [8:0] cnt_ff, nxt_cnt;
   logic [1:0] ch_cur_ff, nxt_ch_cur;
   logic grp_ff, nxt_grp;
   logic [1:0] done_ff, nxt_done;
   logic [8:0] phase_ff, nxt_phase;
   logic flag_ff, nxt_flag;
   logic ie_ff, nxt_ie;
   logic trigger_start_enable_ff, nxt_trigger_start_enable;
   logic stc_ff, nxt_stc;
   logic run_ff, nxt_run;
   logic [1:0] cks_ff, nxt_cks;
   logic [1:0] mode_ff, nxt_mode;
   logic cont_ff, nxt_cont;
   logic [1:0] ch_sel_ff, nxt_ch_sel;
   logic both_ff, nxt_both;
   logic [3:0] src0_ff, nxt_src0;
   logic [3:0] src1_ff, nxt_src1;
   logic stby_ff, nxt_stby;
   localparam int NUM_CH_L = adc_pkg::NUM_CH;

   logic [9:0] data_ff [NUM_CH_L];
   logic [9:0] nxt_data [NUM_CH_L];
   logic ack_ff, nxt_ack;
   logic [31:0] rdat_ff, nxt_rdat;

   logic [31:0] img_stby, img_csr, img_cr, img_tsr;
   logic [2:0] tidx;
   logic [8:0] t_scan;
   logic [8:0] t_spl;
   logic [8:0] t_dmax;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic wr_ok;
   logic wr_csr, wr_cr, wr_tsr, wr_stby;
   logic sw_set, sw_clr;
   logic hw_g0, hw_g1;
   logic start_req;
   logic [1:0] first_ch;
   logic [1:0] last_ch;
   logic scan2;

   adc_start_if start_bus ();

   // Expands byte enables into a bit mask for merging partial writes.
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : lane_mask

   // Merges the write data into a register image under the lane mask.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [31:0] m);
      merge = (old & ~m) | (dat & m);
   endfunction : merge

   adc_trigger_unit u_trig (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .external_trigger_pin_i(external_trigger_pin_i),
      .timer_req_i(timer_req_i),
      .trigger_start_enable_i(trigger_start_enable_ff),
      .src_g0_i(src0_ff),
      .src_g1_i(src1_ff),
      .scan2_i(scan2),
      .start(start_bus.src)
   );

   // Timing figures follow the live clock select; software keeps it stable while running.
   assign tidx = {stc_ff, cks_ff};
   assign t_scan = adc_pkg::SCAN_STATES[tidx];
   assign t_spl = adc_pkg::SPL_STATES[tidx];
   assign t_dmax = adc_pkg::DLY_MAX[cks_ff];
   assign scan2 = (mode_ff == adc_pkg::MODE_SCAN2);

   // A write takes effect on the edge where ack is high, as classic Wishbone expects.
   assign wmask = lane_mask(wb_sel_i);
   assign wval = wb_dat_i & wmask;
   assign wr_ok = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
   assign wr_stby = wr_ok & (wb_adr_i == adc_pkg::OFS_STBY);
   assign wr_csr = wr_ok & ~stby_ff & (wb_adr_i == adc_pkg::OFS_CSR);
   assign wr_cr = wr_ok & ~stby_ff & (wb_adr_i == adc_pkg::OFS_CR);
   assign wr_tsr = wr_ok & ~stby_ff & (wb_adr_i == adc_pkg::OFS_TSR);
   assign sw_set = wr_cr & wmask[adc_pkg::CR_RUN_BIT] & wval[adc_pkg::CR_RUN_BIT];
   assign sw_clr = wr_cr & wmask[adc_pkg::CR_RUN_BIT] & ~wval[adc_pkg::CR_RUN_BIT];

   // Register images with the write merged in; fields are sliced out of these words.
   assign img_stby = merge({31'h0, stby_ff}, wb_dat_i, wmask);
   assign img_csr = merge({24'h0, flag_ff, ie_ff, trigger_start_enable_ff, stc_ff, 4'h0}, wb_dat_i, wmask);
   assign img_cr = merge({23'h0, both_ff, ch_sel_ff, cont_ff, mode_ff, cks_ff, run_ff},
                         wb_dat_i, wmask);
   assign img_tsr = merge({24'h0, src1_ff, src0_ff}, wb_dat_i, wmask);

   // Any start that meets a busy converter is dropped rather than held.
   assign hw_g0 = start_bus.start_g0;
   assign hw_g1 = start_bus.start_g1 & ~hw_g0;
   assign start_req = ~stby_ff & ~run_ff & (sw_set | hw_g0 | hw_g1);

   // The scan range of the active group; single mode uses the selected channel.
   always_comb begin
      first_ch = 2'h0;
      last_ch = 2'h3;
      if (mode_ff == adc_pkg::MODE_SINGLE) begin
         first_ch = ch_sel_ff;
         last_ch = ch_sel_ff;
      end else if (scan2) begin
         first_ch = grp_ff ? 2'h2 : 2'h0;
         last_ch = grp_ff ? 2'h3 : 2'h1;
      end
   end

   // Free-running phase that decides where in the window a start lands.
   always_comb begin
      if (phase_ff >= t_dmax - adc_pkg::DLY_MIN) begin
         nxt_phase = 9'h000;
      end else begin
         nxt_phase = phase_ff + 9'h001;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_ff <= 9'h000;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // Registers and the conversion sequencer share one next-state process.
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_ch_cur = ch_cur_ff;
      nxt_grp = grp_ff;
      nxt_done = done_ff;
      nxt_flag = flag_ff;
      nxt_ie = ie_ff;
      nxt_trigger_start_enable = trigger_start_enable_ff;
      nxt_stc = stc_ff;
      nxt_run = run_ff;
      nxt_cks = cks_ff;
      nxt_mode = mode_ff;
      nxt_cont = cont_ff;
      nxt_ch_sel = ch_sel_ff;
      nxt_both = both_ff;
      nxt_src0 = src0_ff;
      nxt_src1 = src1_ff;
      nxt_stby = stby_ff;
      nxt_data = data_ff;
      if (wr_stby) begin
         nxt_stby = img_stby[adc_pkg::STBY_BIT];
      end
      if (wr_csr) begin
         nxt_ie = img_csr[adc_pkg::CSR_IE_BIT];
         nxt_trigger_start_enable = img_csr[adc_pkg::CSR_TRIGGER_START_ENABLE_BIT];
         nxt_stc = img_csr[adc_pkg::CSR_STC_BIT];
         if (wmask[adc_pkg::CSR_FLAG_BIT] & ~wval[adc_pkg::CSR_FLAG_BIT]) begin
            nxt_flag = 1'b0;
         end
      end
      if (wr_cr) begin
         nxt_cks[0] = img_cr[adc_pkg::CR_CKLO_BIT];
         nxt_cks[1] = img_cr[adc_pkg::CR_CKHI_BIT];
         nxt_mode = img_cr[adc_pkg::CR_MODE_LSB +: 2];
         nxt_cont = img_cr[adc_pkg::CR_CONT_BIT];
         nxt_ch_sel = img_cr[adc_pkg::CR_CH_LSB +: 2];
         nxt_both = img_cr[adc_pkg::CR_BOTH_BIT];
      end
      if (wr_tsr) begin
         nxt_src0 = img_tsr[adc_pkg::TSR_G0_LSB +: 4];
         nxt_src1 = img_tsr[adc_pkg::TSR_G1_LSB +: 4];
      end
      case (st_ff)
         ST_IDLE: begin
            if (start_req) begin
               // Software, timer and pin starts all enter the same delay path.
               nxt_run = 1'b1;
               nxt_grp = scan2 & ~sw_set & ~hw_g0 & hw_g1;
               nxt_ch_cur = (mode_ff == adc_pkg::MODE_SINGLE) ? ch_sel_ff :
                            (scan2 & nxt_grp) ? 2'h2 : 2'h0;
               nxt_cnt = t_dmax - phase_ff - 9'h001;
               nxt_st = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (cnt_ff == 9'h000) begin
               nxt_cnt = t_spl - 9'h001;
               nxt_st = ST_SAMPLE;
            end else begin
               nxt_cnt = cnt_ff - 9'h001;
            end
         end
         ST_SAMPLE: begin
            if (cnt_ff == 9'h000) begin
               nxt_cnt = t_scan - t_spl - 9'h001;
               nxt_st = ST_CONV;
            end else begin
               nxt_cnt = cnt_ff - 9'h001;
            end
         end
         ST_CONV: begin
            if (cnt_ff != 9'h000) begin
               nxt_cnt = cnt_ff - 9'h001;
            end else begin
               // The code is stored raw; full range is CODE_MIN to CODE_MAX.
               nxt_data[ch_cur_ff] = conv_code_i;
               if (ch_cur_ff != last_ch) begin
                  nxt_ch_cur = ch_cur_ff + 2'h1;
                  nxt_cnt = t_spl - 9'h001;
                  nxt_st = ST_SAMPLE;
               end else begin
                  if (scan2 & both_ff) begin
                     nxt_done = done_ff | (grp_ff ? 2'h2 : 2'h1);
                     if (nxt_done == 2'h3) begin
                        nxt_flag = 1'b1;
                        nxt_done = 2'h0;
                     end
                  end else begin
                     nxt_flag = 1'b1;
                  end
                  if (cont_ff & (mode_ff != adc_pkg::MODE_SINGLE)) begin
                     // Restart skips the start delay, so each pass is the fixed time.
                     nxt_ch_cur = first_ch;
                     nxt_cnt = t_spl - 9'h001;
                     nxt_st = ST_SAMPLE;
                  end else begin
                     nxt_run = 1'b0;
                     nxt_st = ST_IDLE;
                  end
               end
            end
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
      // Clearing run mid-conversion aborts; a result already due this cycle still lands.
      if (run_ff & sw_clr) begin
         nxt_run = 1'b0;
         nxt_st = ST_IDLE;
      end
      // Standby holds the sequencer idle whatever else is pending.
      if (nxt_stby) begin
         nxt_run = 1'b0;
         nxt_st = ST_IDLE;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= ST_IDLE;
         cnt_ff <= 9'h000;
         ch_cur_ff <= 2'h0;
         grp_ff <= 1'b0;
         done_ff <= 2'h0;
         flag_ff <= 1'b0;
         ie_ff <= 1'b0;
         trigger_start_enable_ff <= 1'b0;
         stc_ff <= 1'b0;
         run_ff <= 1'b0;
         cks_ff <= adc_pkg::CKS_RST;
         mode_ff <= adc_pkg::MODE_RST;
         cont_ff <= 1'b0;
         ch_sel_ff <= 2'h0;
         both_ff <= 1'b0;
         src0_ff <= adc_pkg::SRC_RST;
         src1_ff <= adc_pkg::SRC_RST;
         stby_ff <= adc_pkg::STBY_RST;
         for (int i = 0; i < NUM_CH_L; i++) begin
            data_ff[i] <= adc_pkg::DATA_RST;
         end
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         ch_cur_ff <= nxt_ch_cur;
         grp_ff <= nxt_grp;
         done_ff <= nxt_done;
         flag_ff <= nxt_flag;
         ie_ff <= nxt_ie;
         trigger_start_enable_ff <= nxt_trigger_start_enable;
         stc_ff <= nxt_stc;
         run_ff <= nxt_run;
         cks_ff <= nxt_cks;
         mode_ff <= nxt_mode;
         cont_ff <= nxt_cont;
         ch_sel_ff <= nxt_ch_sel;
         both_ff <= nxt_both;
         src0_ff <= nxt_src0;
         src1_ff <= nxt_src1;
         stby_ff <= nxt_stby;
         data_ff <= nxt_data;
      end
   end

   // Read data is captured on the request edge so it is stable while ack is high.
   always_comb begin
      nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
      nxt_rdat = 32'h0000_0000;
      if (wb_adr_i == adc_pkg::OFS_STBY) begin
         nxt_rdat[adc_pkg::STBY_BIT] = stby_ff;
      end else if (stby_ff) begin
         nxt_rdat = 32'h0000_0000;
      end else if (wb_adr_i == adc_pkg::OFS_CSR) begin
         nxt_rdat[adc_pkg::CSR_FLAG_BIT] = flag_ff;
         nxt_rdat[adc_pkg::CSR_IE_BIT] = ie_ff;
         nxt_rdat[adc_pkg::CSR_TRIGGER_START_ENABLE_BIT] = trigger_start_enable_ff;
         nxt_rdat[adc_pkg::CSR_STC_BIT] = stc_ff;
      end else if (wb_adr_i == adc_pkg::OFS_CR) begin
         nxt_rdat[adc_pkg::CR_RUN_BIT] = run_ff;
         nxt_rdat[adc_pkg::CR_CKLO_BIT] = cks_ff[0];
         nxt_rdat[adc_pkg::CR_CKHI_BIT] = cks_ff[1];
         nxt_rdat[adc_pkg::CR_MODE_LSB +: 2] = mode_ff;
         nxt_rdat[adc_pkg::CR_CONT_BIT] = cont_ff;
         nxt_rdat[adc_pkg::CR_CH_LSB +: 2] = ch_sel_ff;
         nxt_rdat[adc_pkg::CR_BOTH_BIT] = both_ff;
      end else if (wb_adr_i == adc_pkg::OFS_TSR) begin
         nxt_rdat[adc_pkg::TSR_G0_LSB +: 4] = src0_ff;
         nxt_rdat[adc_pkg::TSR_G1_LSB +: 4] = src1_ff;
      end else if ((wb_adr_i >= adc_pkg::OFS_DATA0) && (wb_adr_i <= adc_pkg::OFS_DATA3) &&
                   (wb_adr_i[1:0] == 2'h0)) begin
         nxt_rdat[adc_pkg::RES_W-1:0] = data_ff[wb_adr_i[3:2]];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
      end
   end

   // Status outputs come straight from state flops.
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign sample_hold_o = (st_ff == ST_SAMPLE);
   assign convert_busy_o = run_ff;
   assign channel_o = ch_cur_ff;
   assign conversion_end_irq_o = flag_ff & ie_ff;

endmodule : adc_ctrl_top
`default_nettype wire

// file: rtl/adc_pkg.sv
package adc_pkg;

   // Register byte offsets on the Wishbone slave.
   localparam logic [4:0] OFS_CSR = 5'h00;
   localparam logic [4:0] OFS_CR = 5'h04;
   localparam logic [4:0] OFS_TSR = 5'h08;
   localparam logic [4:0] OFS_STBY = 5'h0C;
   localparam logic [4:0] OFS_DATA0 = 5'h10;
   localparam logic [4:0] OFS_DATA3 = 5'h1C;

   // Field positions of converter_control_status.
   localparam int CSR_STC_BIT = 4;
   localparam int CSR_TRIGGER_START_ENABLE_BIT = 5;
   localparam int CSR_IE_BIT = 6;
   localparam int CSR_FLAG_BIT = 7;

   // Field positions of converter_control_reg.
   localparam int CR_RUN_BIT = 0;
   localparam int CR_CKLO_BIT = 1;
   localparam int CR_CKHI_BIT = 2;
   localparam int CR_MODE_LSB = 3;
   localparam int CR_CONT_BIT = 5;
   localparam int CR_CH_LSB = 6;
   localparam int CR_BOTH_BIT = 8;

   // Field positions of trigger_source_register and the standby register.
   localparam int TSR_G0_LSB = 0;
   localparam int TSR_G1_LSB = 4;
   localparam int STBY_BIT = 0;

   // Values after reset.
   localparam logic STBY_RST = 1'b1;
   localparam logic [1:0] CKS_RST = 2'h0;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [3:0] SRC_RST = 4'h0;
   localparam logic [9:0] DATA_RST = 10'h000;

   // Operating mode field codes.
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_SCAN4 = 2'h1;
   localparam logic [1:0] MODE_SCAN2 = 2'h2;

   // Trigger source field codes; timer codes index the timer request inputs.
   localparam logic [3:0] SRC_EXT = 4'h0;
   localparam logic [3:0] SRC_TMR_FIRST = 4'h1;
   localparam logic [3:0] SRC_TMR_LAST = 4'h4;

   localparam int NUM_CH = 4;
   localparam int RES_W = 10;
   localparam logic [9:0] CODE_MIN = 10'h000;
   localparam logic [9:0] CODE_MAX = 10'h3FF;

   // Timing in peripheral-clock states, indexed by {extend, clock select}.
   localparam logic [8:0] SCAN_STATES [0:7] = '{9'h0C8, 9'h096, 9'h064, 9'h032,
                                                9'h100, 9'h0C0, 9'h080, 9'h040};
   localparam logic [8:0] SPL_STATES [0:7] = '{9'h018, 9'h012, 9'h00C, 9'h006,
                                              9'h024, 9'h01B, 9'h012, 9'h009};
   // Longest start delay per clock select; the shortest is always two states.
   localparam logic [8:0] DLY_MAX [0:3] = '{9'h006, 9'h005, 9'h004, 9'h003};
   localparam logic [8:0] DLY_MIN = 9'h002;

endpackage : adc_pkg

// file: rtl/adc_start_if.sv
`timescale 1ns/10ps
`default_nettype none
// Start requests from the trigger selector to the sequencer.
interface adc_start_if;
   logic start_g0;
   logic start_g1;
   modport src (output start_g0, output start_g1);
   modport dst (input start_g0, input start_g1);
endinterface : adc_start_if
`default_nettype wire

// file: rtl/adc_trigger_unit.sv
`timescale 1ns/10ps
`default_nettype none
module adc_trigger_unit (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic external_trigger_pin_i,
   input wire logic [3:0] timer_req_i,
   input wire logic trigger_start_enable_i,
   input wire logic [3:0] src_g0_i,
   input wire logic [3:0] src_g1_i,
   input wire logic scan2_i,
   adc_start_if.src start
);

   logic sync1_ff;
   logic sync2_ff;
   logic last_ff;
   logic nxt_sync1;
   logic nxt_sync2;
   logic nxt_last;
   logic ext_fall;

   // Decodes one source field against the current events; prohibited codes never fire.
   function automatic logic src_hit(input logic [3:0] src, input logic fall,
                                    input logic [3:0] tmr);
      logic [3:0] idx;
      idx = src - adc_pkg::SRC_TMR_FIRST;
      if (src == adc_pkg::SRC_EXT) begin
         src_hit = fall;
      end else if (src <= adc_pkg::SRC_TMR_LAST) begin
         src_hit = tmr[idx[1:0]];
      end else begin
         src_hit = 1'b0;
      end
   endfunction : src_hit

   // Only the second and third stages are compared, so a metastable first stage never reaches logic.
   always_comb begin
      nxt_sync1 = external_trigger_pin_i;
      nxt_sync2 = sync1_ff;
      nxt_last = sync2_ff;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
         last_ff <= 1'b1;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         last_ff <= nxt_last;
      end
   end

   // One falling edge gives exactly one request cycle.
   assign ext_fall = last_ff & ~sync2_ff;

   // Group 1 has its own source only in two-channel scan.
   assign start.start_g0 = trigger_start_enable_i &
                           src_hit(src_g0_i, ext_fall, timer_req_i);
   assign start.start_g1 = trigger_start_enable_i & scan2_i &
                           src_hit(src_g1_i, ext_fall, timer_req_i);

endmodule : adc_trigger_unit
`default_nettype wire

// file: testbench/adc_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_sva (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic external_trigger_pin_i,
   input wire logic [3:0] timer_req_i,
   input wire logic sample_hold_o,
   input wire logic convert_busy_o,
   input wire logic [1:0] channel_o,
   input wire logic conversion_end_irq_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   logic [8:0] cnt_ff;
   logic [8:0] nxt_cnt;
   logic prev_ff;
   // Cycles since sampling last began; it only matters at the end of a window or a conversion.
   always_comb begin
      nxt_cnt = (sample_hold_o && !prev_ff) ? 9'h001 : cnt_ff + 9'h001;
   end
   // Registers the counter and the previous sampling level.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff <= 9'h000;
         prev_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         prev_ff <= sample_hold_o;
      end
   end
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   start_delay_a: assert property ($rose(convert_busy_o) |-> ##[2:6] $rose(sample_hold_o))
      else $error("start delay wrong");
   sample_len_a: assert property ($fell(sample_hold_o) && convert_busy_o
      |-> cnt_ff inside {6, 9, 12, 18, 24, 27, 36}) else $error("sampling window wrong");
   conv_len_a: assert property ($fell(convert_busy_o) && !$past(wb_ack_o)
      |-> cnt_ff inside {50, 64, 100, 128, 150, 192, 200, 256}) else $error("conversion wrong");
   irq_clear_a: assert property ($fell(conversion_end_irq_o) |-> $past(wb_ack_o && wb_we_i))
      else $error("irq fell without write");
   irq_set_a: assert property ($rose(conversion_end_irq_o) && !$past(wb_ack_o)
      |-> cnt_ff inside {50, 64, 100, 128, 150, 192, 200, 256}) else $error("irq rose early");
   chan_hold_a: assert property (sample_hold_o && $past(sample_hold_o) |-> $stable(channel_o))
      else $error("channel moved");
   hold_run_a: assert property (sample_hold_o |-> convert_busy_o)
      else $error("sampling while idle");
   start_cause_a: assert property ($rose(convert_busy_o) |-> $past(wb_ack_o && wb_we_i)
      || $past(timer_req_i) != 4'h0 || !$past(external_trigger_pin_i, 3)) else $error("start cause");
   cover property ($fell(convert_busy_o));
   cover property ($rose(conversion_end_irq_o));
   cover property ($rose(convert_busy_o) && $past(timer_req_i) != 4'h0);
endmodule : adc_ctrl_sva
bind adc_ctrl_top adc_ctrl_sva u_adc_ctrl_sva (.mclk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_ack_o, .external_trigger_pin_i, .timer_req_i, .sample_hold_o, .convert_busy_o,
   .channel_o, .conversion_end_irq_o);
`default_nettype wire

// file: testbench/adc_far_end.sv
`timescale 1ns/10ps
`default_nettype none
module adc_far_end (
   input wire logic mclk_i,
   input wire logic [1:0] channel_i,
   output logic ext_pin_o,
   output logic [3:0] timer_req_o,
   output logic [9:0] code_o
);
   // Each channel returns its own code so misplaced results show; channel 0 is full scale.
   assign code_o = adc_pkg::CODE_MAX - {8'h00, channel_i};
   initial begin
      ext_pin_o = 1'b1;
      timer_req_o = 4'h0;
   end
   // One-cycle request on timer line n.
   task automatic tmr(input int n);
      @(posedge mclk_i) timer_req_o <= 4'h1 << n;
      @(posedge mclk_i) timer_req_o <= 4'h0;
   endtask : tmr
   // Sets the trigger pin level; it idles high.
   task automatic pin(input logic v);
      @(posedge mclk_i) ext_pin_o <= v;
   endtask : pin
endmodule : adc_far_end
`default_nettype wire

// file: testbench/adc_ctrl_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_top_tb;
   logic mclk_i, rst_n_i, cyc, stb, we, ack, hold, busy, irq, pin;
   logic [3:0] sel;
   logic [4:0] adr;
   logic [31:0] wdat, rdat;
   logic [3:0] treq;
   logic [9:0] code;
   logic [1:0] ch;
   int n_mismatch = 0;
   int tests_run = 0;
   int nb;
   adc_ctrl_top u_adc_ctrl_top (.mclk_i, .rst_n_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .external_trigger_pin_i(pin), .timer_req_i(treq), .conv_code_i(code),
      .sample_hold_o(hold), .convert_busy_o(busy), .channel_o(ch), .conversion_end_irq_o(irq));
   adc_far_end u_adc_far_end (.mclk_i, .channel_i(ch), .ext_pin_o(pin), .timer_req_o(treq),
      .code_o(code));
   // Free-running 50 MHz clock.
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   // One classic cycle; ack and read data are taken at the rising edge that samples ack high.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int t;
      t = 0;
      @(posedge mclk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      sel <= 4'hF;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge mclk_i);
         t++;
      end while (ack !== 1'b1 && t < 20);
      q = rdat;
      chk("ack", 32'h1, {31'h0, ack});
      cyc <= 1'b0;
      stb <= 1'b0;
      @(negedge mclk_i);
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input string what, input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(what, exp, q);
   endtask : rd
   // Counts cycles until the run level equals v.
   task automatic wait_busy(input logic v);
      nb = 0;
      while (busy !== v && nb < 2000) begin
         @(negedge mclk_i);
         nb++;
      end
   endtask : wait_busy
   task automatic span(input string what, input int lo, input int hi);
      wait_busy(1'b0);
      chk(what, 32'h1, {31'h0, nb >= lo && nb <= hi});
   endtask : span
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   // Cuts a hang short far beyond the several hundred cycles the tests need.
   initial begin
      #400000;
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      sel = 4'h0;
      we = 1'b0;
      adr = 5'h00;
      wdat = 32'h0;
      rst_n_i = 1'b0;
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd("standby", adc_pkg::OFS_STBY, 32'h1);
      wr(adc_pkg::OFS_CR, 32'h7);
      rd("cr_standby", adc_pkg::OFS_CR, 32'h0);
      wr(adc_pkg::OFS_STBY, 32'h0);
      wr(adc_pkg::OFS_CR, 32'h7);
      span("single", 52, 53);
      rd("data0", adc_pkg::OFS_DATA0, 32'h3FF);
      rd("run_cleared", adc_pkg::OFS_CR, 32'h6);
      rd("flag", adc_pkg::OFS_CSR, 32'h80);
      wr(adc_pkg::OFS_CSR, 32'h50);
      wr(adc_pkg::OFS_CR, 32'h7);
      span("single_stc", 66, 67);
      chk("irq", 32'h1, {31'h0, irq});
      wr(adc_pkg::OFS_CSR, 32'h80);
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(adc_pkg::OFS_CR, 32'h1);
      repeat (20) @(negedge mclk_i);
      wr(adc_pkg::OFS_CR, 32'h0);
      chk("abort", 32'h0, {31'h0, busy});
      wr(adc_pkg::OFS_CSR, 32'h20);
      wr(adc_pkg::OFS_TSR, 32'h21);
      wr(adc_pkg::OFS_CR, 32'h17);
      u_adc_far_end.tmr(1);
      wait_busy(1'b0);
      repeat (5) @(negedge mclk_i);
      chk("g1_dropped", 32'h0, {31'h0, busy});
      rd("data1", adc_pkg::OFS_DATA0 + 5'h04, 32'h3FE);
      rd("data2_kept", adc_pkg::OFS_DATA3 - 5'h04, 32'h0);
      u_adc_far_end.tmr(1);
      wait_busy(1'b1);
      chk("tmr_start", 32'h1, {31'h0, nb < 3});
      wait_busy(1'b0);
      rd("data2", adc_pkg::OFS_DATA3 - 5'h04, 32'h3FD);
      wr(adc_pkg::OFS_TSR, 32'h0);
      wr(adc_pkg::OFS_CSR, 32'h0);
      wr(adc_pkg::OFS_CR, 32'h6);
      u_adc_far_end.pin(1'b0);
      repeat (10) @(negedge mclk_i);
      chk("ext_off", 32'h0, {31'h0, busy});
      u_adc_far_end.pin(1'b1);
      wr(adc_pkg::OFS_CSR, 32'h20);
      u_adc_far_end.pin(1'b0);
      wait_busy(1'b1);
      chk("ext_start", 32'h1, {31'h0, nb < 8});
      span("ext_single", 52, 53);
      u_adc_far_end.pin(1'b1);
      wr(adc_pkg::OFS_CR, 32'hF);
      span("scan4", 202, 203);
      rd("data3", adc_pkg::OFS_DATA3, 32'h3FC);
      rd("unaligned", 5'h02, 32'h0);
      tally_and_finish;
   end
endmodule : adc_ctrl_top_tb
`default_nettype wire
